// ### rtl/dcsrv_pkg.sv
// package: register map, field layout, reset values and timing of the dc servo control
package dcsrv_pkg;
  // register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_ENABLE  = 8'h43;
  localparam logic [7:0] IDX_TRIGGER = 8'h44;
  localparam logic [7:0] IDX_TIMER   = 8'h45;
  localparam logic [7:0] IDX_CNT_LN  = 8'h47;
  localparam logic [7:0] IDX_CNT_HP  = 8'h48;
  localparam logic [7:0] IDX_OFF_CH3 = 8'h49;
  localparam logic [7:0] IDX_OFF_CH0 = 8'h4c;
  localparam logic [7:0] IDX_STATUS  = 8'h4d;
  localparam int         IDX_W       = 8;
  // field positions
  localparam int ENA_LSB      = 0;
  localparam int SINGLE_LSB   = 12;
  localparam int SERIES_LSB   = 8;
  localparam int PER_LN_LSB   = 8;
  localparam int PER_HP_LSB   = 0;
  localparam int CALDONE_LSB  = 8;
  localparam int DACWR_LSB    = 4;
  localparam int STARTUP_LSB  = 0;
  localparam int NCH          = 4;
  localparam int PAIR_SIZE    = 2;
  // reset values
  localparam logic [6:0] SERIES_RST = 7'h2a;
  localparam logic [3:0] PERIOD_RST = 4'ha;
  localparam logic [3:0] PERIOD_OFF = 4'h0;
  // correction limits, two's complement, one step is 0.25 mV
  localparam logic [7:0] OFF_MAX = 8'h7f;
  localparam logic [7:0] OFF_MIN = 8'h80;
  localparam logic [7:0] OFF_ONE = 8'h01;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MEAS_TIME_NS  = 64;
  localparam int MEAS_CYC      = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W        = 8;
  localparam int TIMER_BASE_NS = 256000000;
  localparam int TICK_CYC      = TIMER_BASE_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W    = 16;
  // one-hot states of a channel engine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEAS = 2'b10
  } dcsrv_state_t;
endpackage

// ### rtl/dcsrv_chan.sv
// one channel of the servo: measure, step the correction, repeat for a series
`timescale 1ns/1ns
module dcsrv_chan #(
  parameter int MEAS_CYC = dcsrv_pkg::MEAS_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       start_single,
  input  wire logic       start_series,
  input  wire logic       start_periodic,
  input  wire logic [6:0] series_code,
  input  wire logic       meas_above,
  input  wire logic       meas_below,
  output logic            busy_single,
  output logic            busy_series,
  output logic [7:0]      offset
);
  localparam int MEAS_MAX = MEAS_CYC;

  typedef struct packed {
    dcsrv_pkg::dcsrv_state_t          st;
    logic                             single;
    logic                             series;
    logic [6:0]                       left;
    logic [dcsrv_pkg::WAIT_W-1:0]     wait_cnt;
    logic [7:0]                       off;
  } dcsrv_chan_t;

  dcsrv_chan_t s_q;
  dcsrv_chan_t s_d;

  // next state of the engine
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      dcsrv_pkg::ST_IDLE: begin
        if (enable && (start_single || start_series || start_periodic)) begin
          s_d.st       = dcsrv_pkg::ST_MEAS;
          s_d.series   = start_series;
          s_d.single   = start_single && !start_series;
          s_d.left     = series_code;
          s_d.wait_cnt = dcsrv_pkg::WAIT_W'(MEAS_CYC - 1);
        end
      end
      dcsrv_pkg::ST_MEAS: begin
        if (!enable) begin
          s_d.st     = dcsrv_pkg::ST_IDLE;
          s_d.single = 1'b0;
          s_d.series = 1'b0;
        end else if (s_q.wait_cnt != '0) begin
          s_d.wait_cnt = s_q.wait_cnt - 1'b1;
        end else begin
          // one step at most, held inside the 8-bit range
          if (meas_above && s_q.off != dcsrv_pkg::OFF_MIN) begin
            s_d.off = s_q.off - dcsrv_pkg::OFF_ONE;
          end else if (meas_below && !meas_above && s_q.off != dcsrv_pkg::OFF_MAX) begin
            s_d.off = s_q.off + dcsrv_pkg::OFF_ONE;
          end
          if (s_q.series && s_q.left != '0) begin
            s_d.left     = s_q.left - 1'b1;
            s_d.wait_cnt = dcsrv_pkg::WAIT_W'(MEAS_CYC - 1);
          end else begin
            s_d.st     = dcsrv_pkg::ST_IDLE;
            s_d.single = 1'b0;
            s_d.series = 1'b0;
          end
        end
      end
      default: begin
        s_d    = '0;
        s_d.st = dcsrv_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q    <= '0;
      s_q.st <= dcsrv_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_single = s_q.single;
  assign busy_series = s_q.series;
  assign offset      = s_q.off;

  // checks on the engine
  a_step_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.off != $past(s_q.off)) |-> ((s_q.off - $past(s_q.off)) == 8'h01 ||
                                     (s_q.off - $past(s_q.off)) == 8'hff))
    else $error("correction moved by more than one step");
  a_disabled_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> (!s_q.single && !s_q.series && s_q.off == $past(s_q.off)))
    else $error("servo acted on a disabled channel");
  a_single_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.single) |-> ##[1:MEAS_MAX] !s_q.single)
    else $error("single correction did not clear");
  a_clamp_range: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.off == 8'h7f) |=> (s_q.off != 8'h80))
    else $error("correction wrapped past the top");
  a_series_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.st == dcsrv_pkg::ST_IDLE && enable && start_series) |=> s_q.series)
    else $error("series trigger did not start a run");
endmodule

// ### rtl/dcsrv_top.sv
// dc servo control: register slave, periodic timers and four channel engines
`timescale 1ns/1ns
module dcsrv_top #(
  parameter int ADDR_W      = 12,
  parameter int MEAS_CYC    = dcsrv_pkg::MEAS_CYC,
  parameter int TICK_CYCLES = dcsrv_pkg::TICK_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [3:0]        meas_above,
  input  wire logic [3:0]        meas_below,
  input  wire logic [3:0]        dac_write_done_flags,
  input  wire logic [3:0]        startup_done_flags,
  output logic [7:0]             headphone_left_offset,
  output logic [7:0]             headphone_right_offset,
  output logic [7:0]             line_left_offset,
  output logic [7:0]             line_right_offset
);
  localparam int NCH = dcsrv_pkg::NCH;
  localparam int TW  = dcsrv_pkg::TICK_CNT_W;

  // pair 0 is headphone, pair 1 is line
  typedef struct packed {
    logic [3:0]         ena;
    logic [3:0]         go_single;
    logic [3:0]         go_series;
    logic [3:0]         go_per;
    logic [1:0][6:0]    cnt;
    logic [1:0][3:0]    per;
    logic [31:0]        presc;
    logic [1:0][TW-1:0] tk;
    logic               aw_have;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_have;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } dcsrv_top_t;

  dcsrv_top_t s_q;
  dcsrv_top_t s_d;

  logic [3:0]      busy_single;
  logic [3:0]      busy_series;
  logic [3:0][7:0] off_w;
  logic            tick;
  logic [1:0]      fire;

  // an address is mapped only if nothing sits above the index bits
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = ((a >> (dcsrv_pkg::IDX_W + 2)) == '0);
    return ok;
  endfunction

  // register index of a byte address
  function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[dcsrv_pkg::IDX_W+1:2];
    return i;
  endfunction

  // bit mask of the written byte lanes
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // mapped registers and their value on read
  function automatic logic reg_known(input logic [7:0] idx);
    logic k;
    k = (idx == dcsrv_pkg::IDX_ENABLE) || (idx == dcsrv_pkg::IDX_TRIGGER) ||
        (idx == dcsrv_pkg::IDX_TIMER) || (idx == dcsrv_pkg::IDX_CNT_LN) ||
        (idx == dcsrv_pkg::IDX_CNT_HP) || (idx == dcsrv_pkg::IDX_STATUS) ||
        (idx >= dcsrv_pkg::IDX_OFF_CH3 && idx <= dcsrv_pkg::IDX_OFF_CH0);
    return k;
  endfunction

  function automatic logic [31:0] read_reg(input logic [7:0] idx);
    logic [31:0] r;
    logic [7:0]  ch;
    r  = '0;
    ch = dcsrv_pkg::IDX_OFF_CH0 - idx;
    if (idx == dcsrv_pkg::IDX_ENABLE) begin
      r[dcsrv_pkg::ENA_LSB +: NCH] = s_q.ena;
    end else if (idx == dcsrv_pkg::IDX_TRIGGER) begin
      // a pending start already reads busy
      r[dcsrv_pkg::SINGLE_LSB +: NCH] = busy_single | s_q.go_single;
      r[dcsrv_pkg::SERIES_LSB +: NCH] = busy_series | s_q.go_series;
    end else if (idx == dcsrv_pkg::IDX_TIMER) begin
      r[dcsrv_pkg::PER_LN_LSB +: 4] = s_q.per[1];
      r[dcsrv_pkg::PER_HP_LSB +: 4] = s_q.per[0];
    end else if (idx == dcsrv_pkg::IDX_CNT_LN) begin
      r[6:0] = s_q.cnt[1];
    end else if (idx == dcsrv_pkg::IDX_CNT_HP) begin
      r[6:0] = s_q.cnt[0];
    end else if (idx == dcsrv_pkg::IDX_STATUS) begin
      r[dcsrv_pkg::CALDONE_LSB +: NCH] = dac_write_done_flags | startup_done_flags;
      r[dcsrv_pkg::DACWR_LSB +: NCH]   = dac_write_done_flags;
      r[dcsrv_pkg::STARTUP_LSB +: NCH] = startup_done_flags;
    end else if (idx >= dcsrv_pkg::IDX_OFF_CH3 && idx <= dcsrv_pkg::IDX_OFF_CH0) begin
      r[7:0] = off_w[ch[1:0]];
    end
    return r;
  endfunction

  // expiry count of a pair timer: two to the code ticks, minus one
  function automatic logic [TW-1:0] tk_target(input logic [3:0] code);
    logic [TW-1:0] t;
    t = (TW'(1) << code) - TW'(1);
    return t;
  endfunction

  // base tick every 0.256 s and the pair timer expiries
  assign tick = (s_q.presc == 32'(TICK_CYCLES - 1));
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      fire[p] = tick && (s_q.per[p] != dcsrv_pkg::PERIOD_OFF) &&
                (s_q.tk[p] == tk_target(s_q.per[p]));
    end
  end

  // next state: timers, bus channels and register writes
  always_comb begin
    logic [7:0]  widx;
    logic [31:0] wm;
    logic [31:0] wmerged;
    logic [31:0] wtrig;
    logic        wok;
    s_d       = s_q;
    widx      = addr_idx(s_q.aw_addr);
    wok       = addr_ok(s_q.aw_addr) && reg_known(widx);
    wm        = lane_mask(s_q.w_strb);
    wmerged   = (read_reg(widx) & ~wm) | (s_q.w_data & wm);
    wtrig     = s_q.w_data & wm;
    s_d.go_single = '0;
    s_d.go_series = '0;
    s_d.go_per    = '0;
    s_d.presc     = tick ? '0 : s_q.presc + 32'h1;
    // pair timers; a periodic step goes to each enabled channel of the pair
    for (int p = 0; p < 2; p++) begin
      if (s_q.per[p] == dcsrv_pkg::PERIOD_OFF || fire[p]) begin
        s_d.tk[p] = '0;
      end else if (tick) begin
        s_d.tk[p] = s_q.tk[p] + TW'(1);
      end
    end
    // write address and data are taken in either order
    if (s_q.awready && awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (s_q.wready && wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // both halves held: perform the write and answer
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wok ? dcsrv_pkg::RESP_OKAY : dcsrv_pkg::RESP_SLVERR;
      if (wok && widx == dcsrv_pkg::IDX_ENABLE) begin
        s_d.ena = wmerged[dcsrv_pkg::ENA_LSB +: NCH];
      end
      if (wok && widx == dcsrv_pkg::IDX_TRIGGER) begin
        // writing one starts, on enabled channels only
        s_d.go_single = wtrig[dcsrv_pkg::SINGLE_LSB +: NCH] & s_q.ena;
        s_d.go_series = wtrig[dcsrv_pkg::SERIES_LSB +: NCH] & s_q.ena;
      end
      if (wok && widx == dcsrv_pkg::IDX_TIMER) begin
        s_d.per[1] = wmerged[dcsrv_pkg::PER_LN_LSB +: 4];
        s_d.per[0] = wmerged[dcsrv_pkg::PER_HP_LSB +: 4];
        // a new period restarts its pair's count
        for (int p = 0; p < 2; p++) begin
          if (s_d.per[p] != s_q.per[p]) begin
            s_d.tk[p] = '0;
          end
        end
      end
      if (wok && widx == dcsrv_pkg::IDX_CNT_LN) begin
        s_d.cnt[1] = wmerged[6:0];
      end
      if (wok && widx == dcsrv_pkg::IDX_CNT_HP) begin
        s_d.cnt[0] = wmerged[6:0];
      end
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    // periodic starts use the enables as they stand after this cycle's write
    for (int c = 0; c < NCH; c++) begin
      s_d.go_per[c] = fire[c / dcsrv_pkg::PAIR_SIZE] && s_d.ena[c];
    end
    // read channel: one read under way at a time
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && arvalid) begin
      s_d.rvalid = 1'b1;
      if (addr_ok(araddr) && reg_known(addr_idx(araddr))) begin
        s_d.rdata = read_reg(addr_idx(araddr));
        s_d.rresp = dcsrv_pkg::RESP_OKAY;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = dcsrv_pkg::RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  // state register with documented reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.cnt[0] <= dcsrv_pkg::SERIES_RST;
      s_q.cnt[1] <= dcsrv_pkg::SERIES_RST;
      s_q.per[0] <= dcsrv_pkg::PERIOD_RST;
      s_q.per[1] <= dcsrv_pkg::PERIOD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // channel engines; index 0 hp left, 1 hp right, 2 line left, 3 line right
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int P = c / dcsrv_pkg::PAIR_SIZE;
    dcsrv_chan #(
      .MEAS_CYC (MEAS_CYC)
    ) u_chan (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .enable         (s_q.ena[c]),
      .start_single   (s_q.go_single[c]),
      .start_series   (s_q.go_series[c]),
      .start_periodic (s_q.go_per[c]),
      .series_code    (s_q.cnt[P]),
      .meas_above     (meas_above[c]),
      .meas_below     (meas_below[c]),
      .busy_single    (busy_single[c]),
      .busy_series    (busy_series[c]),
      .offset         (off_w[c])
    );
  end

  // bus outputs and corrections straight from flip-flops
  assign awready                = s_q.awready;
  assign wready                 = s_q.wready;
  assign bvalid                 = s_q.bvalid;
  assign bresp                  = s_q.bresp;
  assign arready                = s_q.arready;
  assign rvalid                 = s_q.rvalid;
  assign rresp                  = s_q.rresp;
  assign rdata                  = s_q.rdata;
  assign headphone_left_offset  = off_w[0];
  assign headphone_right_offset = off_w[1];
  assign line_left_offset       = off_w[2];
  assign line_right_offset      = off_w[3];

  // checks on the control
  a_trig_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    ((s_q.go_single | s_q.go_series | s_q.go_per) & ~s_q.ena) == 4'h0)
    else $error("start issued to a disabled channel");
  a_count_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (s_q.cnt[0] == 7'h2a && s_q.cnt[1] == 7'h2a))
    else $error("series counts not at reset value");
  a_period_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (s_q.per[0] == 4'ha && s_q.per[1] == 4'ha && s_q.ena == 4'h0))
    else $error("period codes or enables not at reset value");
  a_period_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.per[0] == 4'h0) |=> (s_q.go_per[1:0] == 2'h0))
    else $error("periodic step with the timer off");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.aw_have && s_q.w_have && !s_q.bvalid) |=> (s_q.bvalid && !s_q.awready))
    else $error("write not answered on the next cycle");
  // read answers and held responses, pair timer fan-out
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.arready && arvalid) |=> (s_q.rvalid && !s_q.arready))
    else $error("read not answered on the next cycle");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.bvalid && !bready) |=> (s_q.bvalid && $stable(s_q.bresp)))
    else $error("write response dropped before it was taken");
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.rvalid && !rready) |=> (s_q.rvalid && $stable(s_q.rdata) && $stable(s_q.rresp)))
    else $error("read data changed before it was taken");
  a_rvalid_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.rvalid && rready) |=> !s_q.rvalid)
    else $error("read data still shown after it was taken");
  a_pair_fire: assert property (@(posedge aclk) disable iff (!aresetn)
    fire[0] |=> (s_q.go_per[1:0] == s_q.ena[1:0]))
    else $error("headphone pair missed a periodic step");
  a_line_fire: assert property (@(posedge aclk) disable iff (!aresetn)
    fire[1] |=> (s_q.go_per[3:2] == s_q.ena[3:2]))
    else $error("line pair missed a periodic step");
  c_single: cover property (@(posedge aclk) disable iff (!aresetn) |s_q.go_single);
  c_series: cover property (@(posedge aclk) disable iff (!aresetn) |s_q.go_series);
  c_periodic: cover property (@(posedge aclk) disable iff (!aresetn) |s_q.go_per);
  c_clamped: cover property (@(posedge aclk) disable iff (!aresetn) off_w[3] == dcsrv_pkg::OFF_MAX);
endmodule

// ### test/dcsrv_top_tb.sv
// self-checking testbench of the dc servo control block
`timescale 1ns/1ns
module dcsrv_top_tb;
  typedef struct {
    logic        we;
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } dcsrv_row_t;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  meas_above;
  logic [3:0]  meas_below;
  logic [7:0]  hp_l;
  logic [7:0]  hp_r;
  logic [7:0]  ln_l;
  logic [7:0]  ln_r;
  int          error_cnt;
  int          compares;
  logic [31:0] v;
  logic [1:0]  r;
  dcsrv_row_t  rows [13];

  // short timer base so periodic firing is reachable
  dcsrv_top #(.ADDR_W(12), .MEAS_CYC(16), .TICK_CYCLES(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas_above(meas_above),
    .meas_below(meas_below), .dac_write_done_flags(4'h5), .startup_done_flags(4'h3),
    .headphone_left_offset(hp_l), .headphone_right_offset(hp_r),
    .line_left_offset(ln_l), .line_right_offset(ln_r));

  // clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // write one word; ready is looked at on the falling edge, released after the taking edge
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] rs);
    logic pa, pw, pb, a, w, b;
    int n;
    pa = 1'b1; pw = 1'b1; pb = 1'b1; n = 0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((pa || pw || pb) && n < 100) begin
      @(negedge aclk);
      a = pa && awready;
      w = pw && wready;
      b = pb && !pa && !pw && bvalid;
      if (b) rs = bresp;
      @(posedge aclk);
      if (a) begin awvalid <= 1'b0; pa = 1'b0; end
      if (w) begin wvalid <= 1'b0; pw = 1'b0; end
      if (b) pb = 1'b0; // bready stays high, no drop and re-raise in one step
      n++;
    end
    if (n >= 100) begin error_cnt++; wrap_up(); end
  endtask

  // read one word
  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rs);
    logic pa, pb, a, b;
    int n;
    pa = 1'b1; pb = 1'b1; n = 0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while ((pa || pb) && n < 100) begin
      @(negedge aclk);
      a = pa && arready;
      b = pb && !pa && rvalid;
      if (b) begin d = rdata; rs = rresp; end
      @(posedge aclk);
      if (a) begin arvalid <= 1'b0; pa = 1'b0; end
      if (b) pb = 1'b0; // rready stays high, no drop and re-raise in one step
      n++;
    end
    if (n >= 100) begin error_cnt++; wrap_up(); end
  endtask

  // poll the trigger register until no run is shown
  task automatic wait_idle();
    logic [31:0] t;
    logic [1:0]  rs;
    int          n;
    n = 0; t = 32'h0000_ff00;
    while (t[15:8] !== 8'h00 && n < 4000) begin
      axi_rd(dcsrv_pkg::IDX_TRIGGER, t, rs);
      n++;
    end
    if (n >= 4000) begin error_cnt++; wrap_up(); end
  endtask

  initial begin
    error_cnt = 0; compares = 0;
    aresetn = 1'b0; awaddr = 12'h000; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hf;
    wvalid = 1'b0; bready = 1'b0; araddr = 12'h000; arvalid = 1'b0; rready = 1'b0;
    meas_above = 4'h0; meas_below = 4'h0;
    // reset values first, then plain read/write cases
    rows = '{'{0, dcsrv_pkg::IDX_ENABLE, 0, 0}, '{0, dcsrv_pkg::IDX_TRIGGER, 0, 0},
      '{0, dcsrv_pkg::IDX_TIMER, 0, 32'h0a0a}, '{0, dcsrv_pkg::IDX_CNT_LN, 0, 32'h2a},
      '{0, dcsrv_pkg::IDX_CNT_HP, 0, 32'h2a}, '{0, dcsrv_pkg::IDX_OFF_CH3, 0, 0},
      '{0, dcsrv_pkg::IDX_OFF_CH0, 0, 0}, '{0, dcsrv_pkg::IDX_STATUS, 0, 32'h753},
      '{1, dcsrv_pkg::IDX_TIMER, 0, 0}, '{1, dcsrv_pkg::IDX_CNT_LN, 32'hffff, 32'h7f},
      '{1, dcsrv_pkg::IDX_CNT_HP, 32'h2, 32'h2}, '{1, dcsrv_pkg::IDX_STATUS, 32'hffff, 32'h753},
      '{1, dcsrv_pkg::IDX_OFF_CH0, 32'h55, 0}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].we) axi_wr(rows[i].idx, rows[i].wd, r);
      axi_rd(rows[i].idx, v, r);
      chk("register row", rows[i].exp, v);
    end
    // unmapped place
    axi_wr(8'h50, 32'h1, r);
    chk("unmapped bresp", {30'h0, dcsrv_pkg::RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h50, v, r);
    chk("unmapped rdata", 32'h0, v);
    chk("unmapped rresp", {30'h0, dcsrv_pkg::RESP_SLVERR}, {30'h0, r});
    // trigger on a disabled channel does nothing
    meas_below <= 4'h1;
    axi_wr(dcsrv_pkg::IDX_TRIGGER, 32'h1000, r);
    axi_rd(dcsrv_pkg::IDX_TRIGGER, v, r);
    chk("trigger disabled", 32'h0, v);
    repeat (40) @(posedge aclk);
    chk("hp left disabled", 32'h0, {24'h0, hp_l});
    axi_wr(dcsrv_pkg::IDX_ENABLE, 32'hf, r);
    // single step on channel 0, busy while running
    axi_wr(dcsrv_pkg::IDX_TRIGGER, 32'h1000, r);
    axi_rd(dcsrv_pkg::IDX_TRIGGER, v, r);
    chk("single busy", 32'h1000, v);
    wait_idle();
    chk("hp left single", 32'h1, {24'h0, hp_l});
    chk("hp right single", 32'h0, {24'h0, hp_r});
    axi_rd(dcsrv_pkg::IDX_OFF_CH0, v, r);
    chk("offset ch0 read", 32'h1, v);
    // series of code 2 on channel 1 gives three steps
    meas_below <= 4'h2;
    axi_wr(dcsrv_pkg::IDX_TRIGGER, 32'h0200, r);
    axi_rd(dcsrv_pkg::IDX_TRIGGER, v, r);
    chk("series busy", 32'h0200, v);
    wait_idle();
    chk("hp right series", 32'h3, {24'h0, hp_r});
    // longest series on channel 3 must stop at the top of the range
    meas_below <= 4'h8;
    axi_wr(dcsrv_pkg::IDX_TRIGGER, 32'h0800, r);
    wait_idle();
    chk("line right clamp", 32'h7f, {24'h0, ln_r});
    axi_rd(dcsrv_pkg::IDX_OFF_CH3, v, r);
    chk("offset ch3 read", 32'h7f, v);
    // code 0 gives one step, downward gives minus one
    meas_below <= 4'h0;
    meas_above <= 4'h4;
    axi_wr(dcsrv_pkg::IDX_CNT_LN, 32'h0, r);
    axi_wr(dcsrv_pkg::IDX_TRIGGER, 32'h0400, r);
    wait_idle();
    chk("line left one step", 32'hff, {24'h0, ln_l});
    // periodic firing on the headphone pair only
    meas_above <= 4'hf;
    axi_wr(dcsrv_pkg::IDX_TIMER, 32'h0002, r);
    repeat (200) @(posedge aclk);
    axi_wr(dcsrv_pkg::IDX_TIMER, 32'h0000, r);
    repeat (40) @(posedge aclk);
    chk("hp left periodic moved", 32'h1, {31'h0, hp_l !== 8'h01});
    chk("line left untouched", 32'hff, {24'h0, ln_l});
    chk("line right untouched", 32'h7f, {24'h0, ln_r});
    chk("hp pair in step", 32'h2, {24'h0, hp_r - hp_l});
    // reset with every channel idle brings the checked fields back to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("hp right after reset", 32'h0, {24'h0, hp_r});
    axi_rd(dcsrv_pkg::IDX_CNT_LN, v, r);
    chk("line count after reset", 32'h2a, v);
    axi_rd(dcsrv_pkg::IDX_TIMER, v, r);
    chk("timer after reset", 32'h0a0a, v);
    axi_rd(dcsrv_pkg::IDX_ENABLE, v, r);
    chk("enable after reset", 32'h0, v);
    wrap_up();
  end
endmodule
